// *** hw/sfr_bank_pkg.sv ***
// sfr_bank_pkg: register offsets, field positions and reset values of the core register bank.
// assumes a 9-bit data memory address and an 8-bit data path.
package sfr_bank_pkg;
  // ==========================================================
  // register offsets
  localparam logic [8:0] indirect_access_port_off = 9'h180;
  localparam logic [8:0] timer_pullup_edge_config_off = 9'h181;
  localparam logic [8:0] prog_counter_low_byte_off = 9'h182;
  localparam logic [8:0] alu_flags_bank_select_off = 9'h183;
  localparam logic [8:0] indirect_pointer_off = 9'h184;
  localparam logic [8:0] port_b_direction_off = 9'h186;
  localparam logic [8:0] port_f_direction_off = 9'h187;
  localparam logic [8:0] port_g_direction_off = 9'h188;
  localparam logic [8:0] prog_counter_high_latch_off = 9'h18a;
  localparam logic [8:0] interrupt_control_off = 9'h18b;
  // converter registers, absent on the variant without it
  localparam logic [8:0] converter_result_off = 9'h01e;
  localparam logic [8:0] converter_control_a_off = 9'h01f;
  localparam logic [8:0] converter_control_b_off = 9'h09f;
  // display memory window
  localparam logic [8:0] display_mem_base = 9'h110;
  localparam int display_mem_words = 16;
  // ==========================================================
  // flag register field positions
  localparam int carry_bit = 0;
  localparam int digit_carry_bit = 1;
  localparam int zero_bit = 2;
  localparam int power_down_bit = 3;
  localparam int timeout_bit = 4;
  localparam int direct_bank_lo_bit = 5;
  localparam int direct_bank_hi_bit = 6;
  localparam int indirect_bank_bit = 7;
  localparam logic [7:0] alu_flag_mask = 8'h07;
  localparam logic [7:0] reset_flag_mask = 8'h18;
  localparam logic [7:0] bank_mask = 8'he0;
  localparam logic [7:0] high_latch_mask = 8'h1f;
  // ==========================================================
  // reset values
  localparam logic [7:0] flags_por_value = 8'h18;
  localparam logic [7:0] config_reset_value = 8'hff;
  localparam logic [7:0] direction_reset_value = 8'hff;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam logic [7:0] intr_keep_mask = 8'h01;
  // ==========================================================
  // reset cause encoding
  typedef enum logic [1:0] {
    cause_none = 2'b00,
    cause_wdt = 2'b01,
    cause_sleep = 2'b11,
    cause_other = 2'b10
  } reset_cause_e;
endpackage : sfr_bank_pkg

// *** hw/display_ram.sv ***
// display_ram: small display memory, also usable as general storage.
// assumes single clock, one write port and one registered read port.
`timescale 1ns/10ps
`default_nettype none
module display_ram #(
  parameter int words = 16,
  parameter int aw = 4
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [aw-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [aw-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [words];
  // ==========================================================
  // storage; every bit is plain ram, pixel or not
  always_ff @(posedge ref_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    rdata <= mem[raddr];
  end
endmodule : display_ram
`default_nettype wire

// *** hw/sfr_bank.sv ***
// sfr_bank: upper special register bank with flag register protection.
// assumes the core drives alu results and reset events on ref_clk; indirect data memory
// sits outside and answers on ext_rdata in the same cycle that ext_re is high.
`timescale 1ns/10ps
`default_nettype none
module sfr_bank #(
  parameter bit has_converter = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic por_event,
  input wire logic [1:0] reset_cause,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic alu_flags_upd,
  input wire logic [7:0] alu_result,
  input wire logic [8:0] alu_a,
  input wire logic [8:0] alu_b,
  input wire logic alu_sub,
  input wire logic clear_instr,
  input wire logic [7:0] conv_result,
  input wire logic [7:0] conv_ctrl_a,
  input wire logic [7:0] conv_ctrl_b,
  output logic ext_we,
  output logic ext_re,
  output logic [8:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  output logic [7:0] flags,
  output logic [7:0] timer_config,
  output logic [7:0] dir_b,
  output logic [7:0] dir_f,
  output logic [7:0] dir_g,
  output logic [7:0] pc_low,
  output logic [7:0] pc_high_latch,
  output logic [7:0] intr_ctrl
);
  // ==========================================================
  // decode
  logic [7:0] next_flags;
  logic [2:0] alu_now;
  logic rd_indirect;
  logic rd_display;
  logic [7:0] rd_hold;
  logic [7:0] disp_rdata;
  logic disp_hit;
  logic [8:0] disp_off;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction : hit

  assign disp_off = addr - sfr_bank_pkg::display_mem_base;
  assign disp_hit = (addr >= sfr_bank_pkg::display_mem_base) &&
    (disp_off < 9'(sfr_bank_pkg::display_mem_words));

  // ==========================================================
  // alu flags: zero, digit carry, carry
  logic [4:0] nib_sum;
  logic [8:0] byte_sum;
  always_comb
  begin
    if (alu_sub)
    begin
      nib_sum = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01;
      byte_sum = {1'b0, alu_a[7:0]} + {1'b0, ~alu_b[7:0]} + 9'h001;
    end
    else
    begin
      nib_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
      byte_sum = {1'b0, alu_a[7:0]} + {1'b0, alu_b[7:0]};
    end
    alu_now = {alu_result == 8'h00, nib_sum[4], byte_sum[8]};
  end

  // ==========================================================
  // flag register next value
  always_comb
  begin
    next_flags = flags;
    if (wr && hit(addr, sfr_bank_pkg::alu_flags_bank_select_off))
    begin
      next_flags = (wdata & ~sfr_bank_pkg::reset_flag_mask) |
        (flags & sfr_bank_pkg::reset_flag_mask);
    end
    if (alu_flags_upd)
    begin
      next_flags[2:0] = alu_now;
    end
    if (clear_instr && hit(addr, sfr_bank_pkg::alu_flags_bank_select_off))
    begin
      next_flags = flags & ~sfr_bank_pkg::bank_mask;
      next_flags[sfr_bank_pkg::zero_bit] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags <= sfr_bank_pkg::flags_por_value;
    end
    else if (por_event)
    begin
      flags <= sfr_bank_pkg::flags_por_value;
    end
    else if (reset_cause != 2'(sfr_bank_pkg::cause_none))
    begin
      flags[7:5] <= 3'b000;
      flags[sfr_bank_pkg::timeout_bit] <= reset_cause != 2'(sfr_bank_pkg::cause_wdt);
      flags[sfr_bank_pkg::power_down_bit] <= reset_cause != 2'(sfr_bank_pkg::cause_sleep);
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // ==========================================================
  // plain control registers
  function automatic logic wr_to(input logic w, input logic [8:0] a, input logic [8:0] off);
    wr_to = w && (a == off);
  endfunction : wr_to

  logic any_reset;
  assign any_reset = por_event || (reset_cause != 2'(sfr_bank_pkg::cause_none));

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_config <= sfr_bank_pkg::config_reset_value;
      dir_b <= sfr_bank_pkg::direction_reset_value;
      dir_f <= sfr_bank_pkg::direction_reset_value;
      dir_g <= sfr_bank_pkg::direction_reset_value;
      pc_low <= sfr_bank_pkg::zero_byte;
      pc_high_latch <= sfr_bank_pkg::zero_byte;
      intr_ctrl <= sfr_bank_pkg::zero_byte;
    end
    else if (any_reset)
    begin
      timer_config <= sfr_bank_pkg::config_reset_value;
      dir_b <= sfr_bank_pkg::direction_reset_value;
      dir_f <= sfr_bank_pkg::direction_reset_value;
      dir_g <= sfr_bank_pkg::direction_reset_value;
      pc_low <= sfr_bank_pkg::zero_byte;
      pc_high_latch <= sfr_bank_pkg::zero_byte;
      // pending flag in bit 0 survives non-power resets
      intr_ctrl <= por_event ? sfr_bank_pkg::zero_byte :
        (intr_ctrl & sfr_bank_pkg::intr_keep_mask);
    end
    else
    begin
      if (wr_to(wr, addr, sfr_bank_pkg::timer_pullup_edge_config_off))
        timer_config <= wdata;
      if (wr_to(wr, addr, sfr_bank_pkg::port_b_direction_off))
        dir_b <= wdata;
      if (wr_to(wr, addr, sfr_bank_pkg::port_f_direction_off))
        dir_f <= wdata;
      if (wr_to(wr, addr, sfr_bank_pkg::port_g_direction_off))
        dir_g <= wdata;
      if (wr_to(wr, addr, sfr_bank_pkg::prog_counter_low_byte_off))
        pc_low <= wdata;
      if (wr_to(wr, addr, sfr_bank_pkg::prog_counter_high_latch_off))
        pc_high_latch <= wdata & sfr_bank_pkg::high_latch_mask;
      if (wr_to(wr, addr, sfr_bank_pkg::interrupt_control_off))
        intr_ctrl <= wdata;
    end
  end

  // ==========================================================
  // indirect pointer, cleared by rstn only, kept over por_event and other resets
  logic [7:0] pointer;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pointer <= sfr_bank_pkg::zero_byte;
    else if (wr_to(wr, addr, sfr_bank_pkg::indirect_pointer_off))
      pointer <= wdata;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_we <= 1'b0;
      ext_re <= 1'b0;
      ext_addr <= 9'h000;
      ext_wdata <= sfr_bank_pkg::zero_byte;
    end
    else
    begin
      ext_we <= wr && hit(addr, sfr_bank_pkg::indirect_access_port_off);
      ext_re <= rd && hit(addr, sfr_bank_pkg::indirect_access_port_off);
      ext_addr <= {flags[sfr_bank_pkg::indirect_bank_bit], pointer};
      ext_wdata <= wdata;
    end
  end

  // ==========================================================
  // display memory
  // all bits are storage
  display_ram #(
    .words(sfr_bank_pkg::display_mem_words),
    .aw(4)
  ) u_disp (
    .ref_clk(ref_clk),
    .we(wr && disp_hit),
    .waddr(disp_off[3:0]),
    .wdata(wdata),
    .raddr(disp_off[3:0]),
    .rdata(disp_rdata)
  );

  // ==========================================================
  // read path; data valid one cycle after rd
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_hold <= sfr_bank_pkg::zero_byte;
      rd_indirect <= 1'b0;
      rd_display <= 1'b0;
    end
    else
    begin
      rd_indirect <= 1'b0;
      rd_display <= rd && disp_hit;
      rd_hold <= sfr_bank_pkg::zero_byte;
      if (rd)
      begin
        case (addr)
          sfr_bank_pkg::timer_pullup_edge_config_off: rd_hold <= timer_config;
          sfr_bank_pkg::prog_counter_low_byte_off: rd_hold <= pc_low;
          sfr_bank_pkg::alu_flags_bank_select_off: rd_hold <= flags;
          sfr_bank_pkg::indirect_pointer_off: rd_hold <= pointer;
          sfr_bank_pkg::port_b_direction_off: rd_hold <= dir_b;
          sfr_bank_pkg::port_f_direction_off: rd_hold <= dir_f;
          sfr_bank_pkg::port_g_direction_off: rd_hold <= dir_g;
          sfr_bank_pkg::prog_counter_high_latch_off: rd_hold <= pc_high_latch;
          sfr_bank_pkg::interrupt_control_off: rd_hold <= intr_ctrl;
          sfr_bank_pkg::converter_result_off: rd_hold <= has_converter ? conv_result : 8'h00;
          sfr_bank_pkg::converter_control_a_off: rd_hold <= has_converter ? conv_ctrl_a : 8'h00;
          sfr_bank_pkg::converter_control_b_off: rd_hold <= has_converter ? conv_ctrl_b : 8'h00;
          sfr_bank_pkg::indirect_access_port_off: rd_indirect <= 1'b1;
          default: rd_hold <= sfr_bank_pkg::zero_byte;
        endcase
      end
    end
  end

  // indirect read answers from outside memory in the same late cycle
  always_comb
  begin
    if (rd_indirect)
      rdata = ext_rdata;
    else if (rd_display)
      rdata = disp_rdata;
    else
      rdata = rd_hold;
  end

  // ==========================================================
  // checks
  property p_reset_flags_protected;
    @(posedge ref_clk) disable iff (!rstn)
    (wr && hit(addr, sfr_bank_pkg::alu_flags_bank_select_off) && !any_reset && !clear_instr)
      |=> (flags[4:3] == $past(flags[4:3]));
  endproperty
  a_reset_flags_protected: assert property (p_reset_flags_protected)
    else $error("reset flags changed by software write");

  property p_alu_wins;
    @(posedge ref_clk) disable iff (!rstn)
    (alu_flags_upd && !clear_instr && !any_reset) |=> (flags[2:0] == $past(alu_now));
  endproperty
  a_alu_wins: assert property (p_alu_wins)
    else $error("alu flags not kept");

  property p_clear_flags;
    @(posedge ref_clk) disable iff (!rstn)
    (clear_instr && hit(addr, sfr_bank_pkg::alu_flags_bank_select_off) && !any_reset)
      |=> (flags[7:5] == 3'b000) && flags[2];
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("clear of flag register wrong");

  property p_por_value;
    @(posedge ref_clk) disable iff (!rstn)
    por_event |=> (flags[7:3] == 5'b00011);
  endproperty
  a_por_value: assert property (p_por_value)
    else $error("power on flag value wrong");

  property p_unmapped_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (rd && addr == 9'h185) |=> (rdata == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_indirect_fwd;
    @(posedge ref_clk) disable iff (!rstn)
    (wr && hit(addr, sfr_bank_pkg::indirect_access_port_off)) |=> ext_we;
  endproperty
  a_indirect_fwd: assert property (p_indirect_fwd)
    else $error("indirect write not forwarded");
endmodule : sfr_bank
`default_nettype wire

// *** dv/sfr_bank_tb.sv ***
// sfr_bank_tb: self-checking bench for the special register bank.
// assumes the bank answers reads one cycle after the read strobe and needs no wait states.
`timescale 1ns/10ps
`default_nettype none
module sfr_bank_tb;
  // ==========================================================
  // stimulus and observation signals
  logic ref_clk, rstn, por_event, wr, rd, alu_flags_upd, alu_sub, clear_instr;
  logic [1:0] reset_cause;
  logic [8:0] addr, alu_a, alu_b, ext_addr;
  logic [7:0] wdata, alu_result, conv_result, conv_ctrl_a, conv_ctrl_b, ext_rdata, ext_wdata;
  logic [7:0] rdata, rdata2, flags, timer_config, dir_b, dir_f, dir_g, pc_low, pc_high_latch;
  logic [7:0] intr_ctrl, rd2_val;
  logic ext_we, ext_re;
  int fails, samples_checked;
  logic [8:0] reg_addr [9] = '{9'h181, 9'h182, 9'h184, 9'h186, 9'h187, 9'h188, 9'h18a, 9'h18b,
    9'h185};
  logic [7:0] reg_rst [9] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [7:0] reg_wr [9] = '{8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'h05, 8'ha5, 8'h00};
  // ==========================================================
  // devices under test: full variant and variant without converter
  sfr_bank #(.has_converter(1'b1)) dut (.ref_clk(ref_clk), .rstn(rstn), .por_event(por_event),
    .reset_cause(reset_cause), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .alu_flags_upd(alu_flags_upd), .alu_result(alu_result), .alu_a(alu_a), .alu_b(alu_b),
    .alu_sub(alu_sub), .clear_instr(clear_instr), .conv_result(conv_result),
    .conv_ctrl_a(conv_ctrl_a), .conv_ctrl_b(conv_ctrl_b), .ext_we(ext_we), .ext_re(ext_re),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .flags(flags),
    .timer_config(timer_config), .dir_b(dir_b), .dir_f(dir_f), .dir_g(dir_g), .pc_low(pc_low),
    .pc_high_latch(pc_high_latch), .intr_ctrl(intr_ctrl));
  sfr_bank #(.has_converter(1'b0)) dut_noconv (.ref_clk(ref_clk), .rstn(rstn),
    .por_event(por_event), .reset_cause(reset_cause), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata2), .alu_flags_upd(alu_flags_upd), .alu_result(alu_result),
    .alu_a(alu_a), .alu_b(alu_b), .alu_sub(alu_sub), .clear_instr(clear_instr),
    .conv_result(conv_result), .conv_ctrl_a(conv_ctrl_a), .conv_ctrl_b(conv_ctrl_b),
    .ext_we(), .ext_re(), .ext_addr(), .ext_wdata(), .ext_rdata(ext_rdata), .flags(),
    .timer_config(), .dir_b(), .dir_f(), .dir_g(), .pc_low(), .pc_high_latch(), .intr_ctrl());
  // ==========================================================
  // clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    results();
  end
  // ==========================================================
  // access tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h got %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    rd2_val = rdata2;
    chk(name, exp, rdata);
  endtask : rd_chk
  // flag write racing an alu update in the same cycle
  task automatic alu_wr(input logic s, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] res, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= 9'h183;
    wdata <= 8'hff;
    wr <= 1'b1;
    alu_flags_upd <= 1'b1;
    alu_sub <= s;
    alu_a <= {1'b0, a};
    alu_b <= {1'b0, b};
    alu_result <= res;
    @(posedge ref_clk);
    wr <= 1'b0;
    alu_flags_upd <= 1'b0;
    #1;
    chk("flags alu", exp, flags);
  endtask : alu_wr
  task automatic evt(input logic p, input logic [1:0] c);
    @(posedge ref_clk);
    por_event <= p;
    reset_cause <= c;
    @(posedge ref_clk);
    por_event <= 1'b0;
    reset_cause <= 2'b00;
    #1;
  endtask : evt
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  // ==========================================================
  // main sequence
  initial
  begin
    rstn = 1'b0; por_event = 1'b0; reset_cause = 2'b00; addr = 9'h000; wdata = 8'h00;
    wr = 1'b0; rd = 1'b0; alu_flags_upd = 1'b0; alu_result = 8'h00; alu_a = 9'h000;
    alu_b = 9'h000; alu_sub = 1'b0; clear_instr = 1'b0; conv_result = 8'h81;
    conv_ctrl_a = 8'h84; conv_ctrl_b = 8'h83; ext_rdata = 8'h3c;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    // alu bits load 0 at power-on but are left unchecked, so masked
    chk("flags por", 8'h18, flags & 8'hf8);
    // unmapped writes first, so any leak shows in the reset values
    wr_reg(9'h185, 8'h5a);
    wr_reg(9'h19f, 8'h5a);
    for (int i = 0; i < 9; i++) rd_chk(reg_addr[i], reg_rst[i], "reset value");
    for (int i = 0; i < 9; i++) wr_reg(reg_addr[i], 8'ha5);
    for (int i = 0; i < 9; i++) rd_chk(reg_addr[i], reg_wr[i], "write readback");
    chk("dir_b port", 8'ha5, dir_b);
    chk("dir_f port", 8'ha5, dir_f);
    chk("timer_config port", 8'ha5, timer_config);
    chk("pc_low port", 8'ha5, pc_low);
    chk("pc_high_latch port", 8'h05, pc_high_latch);
    // flags altered by plain moves only; reset flag bits ignore them
    wr_reg(9'h183, 8'he7);
    rd_chk(9'h183, 8'hff, "flags write");
    wr_reg(9'h183, 8'h00);
    rd_chk(9'h183, 8'h18, "flags write zero");
    // alu wins over the write; borrow polarity on subtract
    alu_wr(1'b1, 8'h05, 8'h03, 8'h02, 8'hfb);
    alu_wr(1'b1, 8'h03, 8'h05, 8'hfe, 8'hf8);
    alu_wr(1'b0, 8'hff, 8'h01, 8'h00, 8'hff);
    alu_wr(1'b0, 8'h10, 8'h20, 8'h30, 8'hf8);
    // clear of flag register
    wr_reg(9'h183, 8'he7);
    @(posedge ref_clk);
    addr <= 9'h183;
    clear_instr <= 1'b1;
    @(posedge ref_clk);
    clear_instr <= 1'b0;
    #1;
    chk("flags clear", 8'h1f, flags);
    // indirect port goes through the pointer, high bank bit included
    wr_reg(9'h184, 8'h42);
    wr_reg(9'h183, 8'h80);
    wr_reg(9'h180, 8'h5a);
    #1;
    chk("ext_we", 8'h01, {7'h00, ext_we});
    chk("ext_addr low", 8'h42, ext_addr[7:0]);
    chk("ext_addr bank", 8'h01, {7'h00, ext_addr[8]});
    chk("ext_wdata", 8'h5a, ext_wdata);
    rd_chk(9'h180, 8'h3c, "indirect read");
    chk("ext_re", 8'h01, {7'h00, ext_re});
    rd_chk(9'h184, 8'h42, "pointer kept");
    // converter addresses on both variants; reserved bits written clear
    wr_reg(9'h01f, 8'h00);
    rd_chk(9'h01e, 8'h81, "conv result");
    chk("conv result absent", 8'h00, rd2_val);
    rd_chk(9'h01f, 8'h84, "conv ctrl a");
    chk("conv ctrl a absent", 8'h00, rd2_val);
    rd_chk(9'h09f, 8'h83, "conv ctrl b");
    chk("conv ctrl b absent", 8'h00, rd2_val);
    // display memory, pixel-less bits included
    for (int i = 0; i < 16; i++) wr_reg(9'h110 + 9'(i), 8'hc3 ^ 8'(i));
    for (int i = 0; i < 16; i++) rd_chk(9'h110 + 9'(i), 8'hc3 ^ 8'(i), "display mem");
    // reset causes other than power-on
    wr_reg(9'h183, 8'he5);
    wr_reg(9'h18b, 8'hff);
    evt(1'b0, sfr_bank_pkg::cause_wdt);
    chk("flags wdt", 8'h0d, flags);
    chk("intr keep", 8'h01, intr_ctrl);
    evt(1'b0, sfr_bank_pkg::cause_sleep);
    chk("flags sleep", 8'h15, flags);
    wr_reg(9'h183, 8'he5);
    evt(1'b0, sfr_bank_pkg::cause_other);
    chk("flags other", 8'h1d, flags);
    // direction register moved off its reset value so power-on must restore it
    wr_reg(9'h188, 8'h5a);
    evt(1'b1, sfr_bank_pkg::cause_none);
    chk("flags por event", 8'h18, flags & 8'hf8);
    chk("dir_g por event", 8'hff, dir_g);
    chk("intr por event", 8'h00, intr_ctrl);
    results();
  end
endmodule : sfr_bank_tb
`default_nettype wire
